// File: rtl/iesp_pkg.sv
// Package: register map, field layout and source numbering of the interrupt register block
package iesp_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_SENSE_SELECT = 8'hf4;
    localparam logic [7:0] ADDR_REQ_ENABLE = 8'hf5;
    localparam logic [7:0] ADDR_REQ_FLAGS = 8'hf6;
    localparam logic [7:0] ADDR_PRIO_A = 8'hf8;
    localparam logic [7:0] ADDR_PRIO_B = 8'hf9;
    localparam logic [7:0] ADDR_PENDING = 8'hfa;
    // ------------------------------------------------------------------
    // Reset values and field masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [5:0] RESET_REQ = 6'h00;
    localparam logic [7:0] PRIO_B_MASK = 8'hee;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int NUM_EXT = 6;
    localparam int NUM_SRC = 18;
    localparam int SRC_IDX_W = 5;
    localparam logic [4:0] NO_SOURCE = 5'h1f;
    // Source numbering, also the fixed default order (lower wins)
    localparam int SRC_EXT0 = 0;
    localparam int SRC_WDOG = 6;
    localparam int SRC_TIMER0 = 7;
    localparam int SRC_DMA = 12;
    localparam int SRC_SERIAL0 = 13;
    localparam int SRC_ADC = 15;
    localparam int SRC_INT_W = 12;
    // Priority bit positions
    localparam int PA_EXT0 = 7;
    localparam int PA_EXT1 = 6;
    localparam int PA_EXT23 = 5;
    localparam int PA_EXT45 = 4;
    localparam int PA_WDOG = 3;
    localparam int PA_TIMER0 = 2;
    localparam int PB_TIMER3 = 7;
    localparam int PB_TIMER4 = 6;
    localparam int PB_DMA = 5;
    localparam int PB_SERIAL0 = 3;
    localparam int PB_SERIAL1 = 2;
    localparam int PB_ADC = 1;
    localparam int PB_BITS_SPARE = 0;
endpackage : iesp_pkg

// File: rtl/iesp_sel_if.sv
// Interface: pending vector and level map from the register core to the priority picker
interface iesp_sel_if #(parameter int N = 18, parameter int W = 5);
    logic [N-1:0] pending;
    logic [N-1:0] level;
    logic [W-1:0] winner;
    logic found;
    modport core (output pending, output level, input winner, input found);
    modport pick (input pending, input level, output winner, output found);
endinterface : iesp_sel_if

// File: rtl/iesp_prio_pick.sv
// Fixed-order picker that prefers high-level sources
module iesp_prio_pick #(parameter int N = 18, parameter int W = 5) (
    iesp_sel_if.pick sel
);
    // ------------------------------------------------------------------
    // Two passes: level 0 first, then level 1 overriding it; lowest index wins a tie
    // ------------------------------------------------------------------
    always_comb begin
        sel.winner = '1;
        sel.found = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (sel.pending[i] && !sel.level[i]) begin
                sel.winner = W'(i);
                sel.found = 1'b1;
            end
        end
        for (int i = N - 1; i >= 0; i--) begin
            if (sel.pending[i] && sel.level[i]) begin
                sel.winner = W'(i);
                sel.found = 1'b1;
            end
        end
    end
endmodule // iesp_prio_pick

// File: rtl/iesp_irq_regs.sv
// Interrupt enable, status flag and priority register block with request selection
// Function
// - Six enable bits 5..0 gate the external requests, 1 enables, all reset to 0.
// - A flag sets while its input is low in level mode or on a falling edge in edge mode.
// - A flag clears by writing 0 only after software has read it as 1.
// - In level mode, exception handling clears the flag when the input is back high.
// - In edge mode, exception handling clears the flag regardless of the input level.
// - Flag bits take only 0 writes, 1 writes do nothing, reset 0, bits 7 and 6 unused.
// - Each priority bit puts its sources at level 1 when set and level 0 when clear.
// - Priority A bits map to request 0, 1, 2-3, 4-5, watchdog/refresh, timers 0..2.
// - Priority B bits map to timers 3,4, DMA, serial 0,1, converter; bits 4 and 0 unused.
module iesp_irq_regs import iesp_pkg::*; #(
    parameter int NEXT = NUM_EXT
) (
    ref_clk,
    nrst,
    regAddr,
    regWdata,
    regWrite,
    regRead,
    regRdata,
    extReqN,
    intReq,
    excAck,
    excAckId,
    cpuReq,
    cpuReqId,
    cpuReqHigh
);
    input wire logic ref_clk;
    input wire logic nrst;
    input wire logic [7:0] regAddr;
    input wire logic [7:0] regWdata;
    input wire logic regWrite;
    input wire logic regRead;
    output logic [7:0] regRdata;
    input wire logic [NEXT-1:0] extReqN;
    input wire logic [SRC_INT_W-1:0] intReq;
    input wire logic excAck;
    input wire logic [SRC_IDX_W-1:0] excAckId;
    output logic cpuReq;
    output logic [SRC_IDX_W-1:0] cpuReqId;
    output logic cpuReqHigh;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NEXT-1:0] sync1;
        logic [NEXT-1:0] sync2;
        logic [NEXT-1:0] prevLvl;
        logic [NEXT-1:0] senseSel;
        logic [NEXT-1:0] enable;
        logic [NEXT-1:0] flags;
        logic [NEXT-1:0] readOne;
        logic [7:0] prioA;
        logic [7:0] prioB;
        logic [7:0] rdata;
        logic req;
        logic [SRC_IDX_W-1:0] reqId;
        logic reqHigh;
    } iesp_state_t;

    iesp_state_t st_reg;
    iesp_state_t st_next;

    iesp_sel_if #(.N(NUM_SRC), .W(SRC_IDX_W)) sel ();

    iesp_prio_pick #(.N(NUM_SRC), .W(SRC_IDX_W)) u_pick (
        .sel(sel)
    );

    // ------------------------------------------------------------------
    // Source vectors for the picker
    // ------------------------------------------------------------------
    logic [NEXT-1:0] extPresent;
    assign extPresent = st_reg.flags & st_reg.enable;
    assign sel.pending = {intReq, extPresent};

    // Level map built from both priority registers
    always_comb begin
        sel.level = '0;
        sel.level[SRC_EXT0] = st_reg.prioA[PA_EXT0];
        sel.level[SRC_EXT0 + 1] = st_reg.prioA[PA_EXT1];
        sel.level[SRC_EXT0 + 2] = st_reg.prioA[PA_EXT23];
        sel.level[SRC_EXT0 + 3] = st_reg.prioA[PA_EXT23];
        sel.level[SRC_EXT0 + 4] = st_reg.prioA[PA_EXT45];
        sel.level[SRC_EXT0 + 5] = st_reg.prioA[PA_EXT45];
        sel.level[SRC_WDOG] = st_reg.prioA[PA_WDOG];
        for (int t = 0; t < 3; t++) begin
            sel.level[SRC_TIMER0 + t] = st_reg.prioA[PA_TIMER0 - t];
        end
        sel.level[SRC_TIMER0 + 3] = st_reg.prioB[PB_TIMER3];
        sel.level[SRC_TIMER0 + 4] = st_reg.prioB[PB_TIMER4];
        sel.level[SRC_DMA] = st_reg.prioB[PB_DMA];
        sel.level[SRC_SERIAL0] = st_reg.prioB[PB_SERIAL0];
        sel.level[SRC_SERIAL0 + 1] = st_reg.prioB[PB_SERIAL1];
        sel.level[SRC_ADC] = st_reg.prioB[PB_ADC];
        // Two spare source slots above the converter stay at level 0
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic [NEXT-1:0] setEv;
    logic [NEXT-1:0] excClr;
    logic [NEXT-1:0] swClr;
    logic [NEXT-1:0] wrFlags;

    always_comb begin
        st_next = st_reg;
        setEv = '0;
        excClr = '0;
        swClr = '0;
        wrFlags = regWdata[NEXT-1:0];
        // Pins pass three flops; the second and, in edge mode, the third are looked at
        st_next.sync1 = extReqN;
        st_next.sync2 = st_reg.sync1;
        st_next.prevLvl = st_reg.sync2;
        for (int n = 0; n < NEXT; n++) begin
            if (st_reg.senseSel[n]) begin
                setEv[n] = st_reg.prevLvl[n] && !st_reg.sync2[n];
            end else begin
                setEv[n] = !st_reg.sync2[n];
            end
            if (excAck && excAckId == SRC_IDX_W'(n)) begin
                if (st_reg.senseSel[n]) begin
                    excClr[n] = 1'b1;
                end else begin
                    excClr[n] = st_reg.sync2[n];
                end
            end
            // Only a 0 write after a read of 1 clears; 1 writes are ignored
            if (regWrite && regAddr == ADDR_REQ_FLAGS) begin
                swClr[n] = !wrFlags[n] && st_reg.readOne[n];
            end
        end
        // Hardware set wins over any clear in the same cycle
        st_next.flags = (st_reg.flags & ~(swClr | excClr)) | setEv;
        // Read-of-1 arming: cleared by the consuming write or when the flag drops
        if (regRead && regAddr == ADDR_REQ_FLAGS) begin
            st_next.readOne = st_reg.flags;
        end else if (regWrite && regAddr == ADDR_REQ_FLAGS) begin
            st_next.readOne = '0;
        end else begin
            st_next.readOne = st_reg.readOne & st_reg.flags;
        end
        // Register writes
        if (regWrite) begin
            if (regAddr == ADDR_REQ_ENABLE) begin
                st_next.enable = regWdata[NEXT-1:0];
            end else if (regAddr == ADDR_SENSE_SELECT) begin
                st_next.senseSel = regWdata[NEXT-1:0];
            end else if (regAddr == ADDR_PRIO_A) begin
                st_next.prioA = regWdata;
            end else if (regAddr == ADDR_PRIO_B) begin
                st_next.prioB = regWdata;
            end
        end
        // Read data, valid only in the cycle after the strobe
        st_next.rdata = UNMAPPED_READ;
        if (regRead) begin
            if (regAddr == ADDR_REQ_ENABLE) begin
                st_next.rdata = 8'(st_reg.enable);
            end else if (regAddr == ADDR_SENSE_SELECT) begin
                st_next.rdata = 8'(st_reg.senseSel);
            end else if (regAddr == ADDR_REQ_FLAGS) begin
                st_next.rdata = 8'(st_reg.flags);
            end else if (regAddr == ADDR_PRIO_A) begin
                st_next.rdata = st_reg.prioA;
            end else if (regAddr == ADDR_PRIO_B) begin
                st_next.rdata = st_reg.prioB;
            end else if (regAddr == ADDR_PENDING) begin
                st_next.rdata = {sel.found, 2'b00, sel.winner};
            end
        end
        // Registered request to the CPU
        st_next.req = sel.found;
        st_next.reqId = sel.found ? sel.winner : NO_SOURCE;
        st_next.reqHigh = sel.found && sel.level[sel.winner];
    end

    // ------------------------------------------------------------------
    // State register; inputs idle high after reset so no false edge
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.sync1 <= '1;
            st_reg.sync2 <= '1;
            st_reg.prevLvl <= '1;
            st_reg.enable <= RESET_REQ;
            st_reg.flags <= RESET_REQ;
            st_reg.prioA <= RESET_BYTE;
            st_reg.prioB <= RESET_BYTE;
            st_reg.reqId <= NO_SOURCE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, straight from flops
    // ------------------------------------------------------------------
    assign regRdata = st_reg.rdata;
    assign cpuReq = st_reg.req;
    assign cpuReqId = st_reg.reqId;
    assign cpuReqHigh = st_reg.reqHigh;
endmodule // iesp_irq_regs

// File: dv/iesp_irq_regs_properties.sv
// Checker: port-level properties of the interrupt register block
module iesp_irq_checker import iesp_pkg::*; (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic [SRC_INT_W-1:0] intReq,
    input wire logic cpuReq,
    input wire logic [SRC_IDX_W-1:0] cpuReqId,
    input wire logic cpuReqHigh
);
    // --------------------------------------------------------------
    // Properties, one clock domain
    // --------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdata == 8'h00)
        else $error("read data not idle");
    AST_ENABLE_TOP: assert property ($past(regRead) && $past(regAddr) == ADDR_REQ_ENABLE
        |-> regRdata[7:6] == 2'b00) else $error("enable top bits set");
    AST_FLAG_TOP: assert property ($past(regRead) && $past(regAddr) == ADDR_REQ_FLAGS
        |-> regRdata[7:6] == 2'b00) else $error("flag top bits set");
    AST_IDLE_ID: assert property (!cpuReq |-> cpuReqId == NO_SOURCE)
        else $error("idle id wrong");
    AST_REQ_ID: assert property (cpuReq |-> cpuReqId < 5'd18)
        else $error("winner out of range");
    AST_HIGH_REQ: assert property (cpuReqHigh |-> cpuReq)
        else $error("high level without request");
    AST_SPARE_LOW: assert property (cpuReq && cpuReqId >= 5'd16 |-> !cpuReqHigh)
        else $error("spare source at high level");
    // Slack of three cycles covers a registered request path
    AST_INT_SOURCE: assert property (cpuReq && cpuReqId inside {[6:15]}
        |-> $past(intReq) != 0 || $past(intReq, 2) != 0 || $past(intReq, 3) != 0)
        else $error("on-chip winner with no request");
endmodule // iesp_irq_checker
bind iesp_irq_regs iesp_irq_checker chk (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regRead(regRead), .regRdata(regRdata), .intReq(intReq), .cpuReq(cpuReq),
    .cpuReqId(cpuReqId), .cpuReqHigh(cpuReqHigh));

// File: dv/iesp_pin_model.sv
// Far-side model: external request pins and CPU exception acknowledge
module iesp_pin_model import iesp_pkg::*; (
    input wire logic [5:0] pinLow,
    input wire logic ackGo,
    input wire logic cpuReq,
    input wire logic [SRC_IDX_W-1:0] cpuReqId,
    output logic [5:0] extReqN,
    output logic excAck,
    output logic [SRC_IDX_W-1:0] excAckId
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins are pulled high unless a source pulls them low
    assign extReqN = ~pinLow;
    // The CPU only takes the winner it is shown, never an idle controller
    assign excAck = ackGo && cpuReq;
    assign excAckId = cpuReqId;
endmodule // iesp_pin_model

// File: dv/testbench.sv
// Testbench: register access, flag set and clear, exception clearing, priority selection
module testbench import iesp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdata;
    logic [5:0] pinLow = 6'h00;
    logic [5:0] extReqN;
    logic [SRC_INT_W-1:0] intReq = '0;
    logic ackGo = 1'b0;
    logic excAck;
    logic [SRC_IDX_W-1:0] excAckId;
    logic cpuReq;
    logic [SRC_IDX_W-1:0] cpuReqId;
    logic cpuReqHigh;
    int mismatches = 0;
    int n_compared = 0;
    // ----------------------------------------------------------------
    // Clock, design and far side
    // ----------------------------------------------------------------
    initial forever #2.5 ref_clk = ~ref_clk;
    iesp_irq_regs uut (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .extReqN(extReqN),
        .intReq(intReq), .excAck(excAck), .excAckId(excAckId), .cpuReq(cpuReq),
        .cpuReqId(cpuReqId), .cpuReqHigh(cpuReqHigh));
    iesp_pin_model partner (.pinLow(pinLow), .ackGo(ackGo), .cpuReq(cpuReq),
        .cpuReqId(cpuReqId), .extReqN(extReqN), .excAck(excAck), .excAckId(excAckId));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Winner view: bit 7 high level, bit 6 request, bits 4..0 source, 8'h1f when idle
    task automatic win(input logic [7:0] exp);
        check({cpuReqHigh, cpuReq, 1'b0, cpuReqId}, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        check(regRdata, exp);
    endtask
    task automatic pins(input logic [5:0] v, input int n);
        @(posedge ref_clk);
        pinLow <= v;
        cyc(n);
    endtask
    task automatic ack;
        @(posedge ref_clk);
        ackGo <= 1'b1;
        @(posedge ref_clk);
        ackGo <= 1'b0;
        cyc(4);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_rw;
        logic [7:0] adr [6] = '{ADDR_SENSE_SELECT, ADDR_REQ_ENABLE, ADDR_REQ_FLAGS,
            ADDR_PRIO_A, ADDR_PRIO_B, 8'hf7};
        foreach (adr[i]) rd(adr[i], 8'h00);
        win(8'h1f);
        wr(ADDR_REQ_ENABLE, 8'h3f);
        rd(ADDR_REQ_ENABLE, 8'h3f);
        wr(ADDR_PRIO_A, 8'ha5);
        rd(ADDR_PRIO_A, 8'ha5);
        wr(ADDR_PRIO_B, 8'hee);
        rd(ADDR_PRIO_B, 8'hee);
        wr(8'hf7, 8'hff);
        rd(8'hf7, 8'h00);
        wr(ADDR_PRIO_A, 8'h00);
        wr(ADDR_PRIO_B, 8'h00);
    endtask
    task automatic t_level_clear;
        wr(ADDR_REQ_ENABLE, 8'h01);
        pins(6'h01, 5);
        win(8'h40);
        pins(6'h00, 4);
        wr(ADDR_REQ_FLAGS, 8'h00);
        rd(ADDR_REQ_FLAGS, 8'h01);
        // All ones: no flag may clear, and the write spends the read arm
        wr(ADDR_REQ_FLAGS, 8'h3f);
        rd(ADDR_REQ_FLAGS, 8'h01);
        wr(ADDR_REQ_FLAGS, 8'h00);
        rd(ADDR_REQ_FLAGS, 8'h00);
        wr(ADDR_REQ_ENABLE, 8'h00);
        pins(6'h02, 5);
        rd(ADDR_REQ_FLAGS, 8'h02);
        win(8'h1f);
        pins(6'h00, 4);
        rd(ADDR_REQ_FLAGS, 8'h02);
        wr(ADDR_REQ_FLAGS, 8'h00);
        rd(ADDR_REQ_FLAGS, 8'h00);
    endtask
    // Edge source cleared by handling with its pin still low; level source only once high
    task automatic t_handling;
        wr(ADDR_SENSE_SELECT, 8'h04);
        wr(ADDR_REQ_ENABLE, 8'h0c);
        pins(6'h04, 5);
        win(8'h42);
        ack();
        rd(ADDR_REQ_FLAGS, 8'h00);
        pins(6'h08, 5);
        win(8'h43);
        ack();
        rd(ADDR_REQ_FLAGS, 8'h08);
        pins(6'h00, 4);
        ack();
        rd(ADDR_REQ_FLAGS, 8'h00);
        win(8'h1f);
    endtask
    task automatic t_priority;
        @(posedge ref_clk);
        intReq <= 12'h201;
        cyc(4);
        win(8'h46);
        wr(ADDR_PRIO_B, 8'h02);
        cyc(3);
        win(8'hcf);
        wr(ADDR_PRIO_A, 8'h08);
        cyc(3);
        win(8'hc6);
        rd(ADDR_PENDING, 8'h86);
        @(posedge ref_clk);
        intReq <= 12'h400;
        cyc(4);
        win(8'h50);
        @(posedge ref_clk);
        intReq <= 12'h000;
        cyc(4);
        win(8'h1f);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence after a two-cycle reset
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset_rw();
        t_level_clear();
        t_handling();
        t_priority();
        tally_and_finish();
    end
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        #20000;
        mismatches++;
        tally_and_finish();
    end
endmodule // testbench
